// ==== src/lvds_map_pkg.sv ====
// Constants for the seven-to-one display link receiver
// Operation
// - Each lane carries seven bits per link period; receiver restores seven per lane.
// - Receiver samples bit n mid-slot, at (n plus half) times period over seven.
// - Stream position k lands on output k; lane three carries low colour bits.
// - High-bit arrangement moves colour 0-5 to lanes 0-2, 6-7 to lane three.
// - 18-bit use takes the low-bit arrangement, lane three unconnected.
// - 18-bit use keeps upper six colour bits, drops the lowest two.
// - Four lanes give 28 outputs, three lanes give 21 outputs.
// - Low-bit arrangement: lane zero red 2-7, green 2; lane one green/blue.
package lvds_map_pkg;

	// =====================================================================
	// Link framing
	localparam int SLOTS = 7;
	localparam int MAX_LANES = 4;
	localparam int WORD_W = 28;
	localparam int LAST_SLOT = 6;
	localparam int CLK_PERIOD_NS = 25;

	// =====================================================================
	// Output position of each serial slot, index is lane*7 + slot
	localparam logic [WORD_W-1:0][4:0] SLOT_POS = {
		5'h17, 5'h11, 5'h10, 5'h0b, 5'h0a, 5'h05, 5'h1b,
		5'h1a, 5'h19, 5'h18, 5'h16, 5'h15, 5'h14, 5'h13,
		5'h12, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08,
		5'h07, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

	// =====================================================================
	// Colour bit sources, entry 7 is the colour MSB
	localparam logic [7:0][4:0] RED_LO = {
		5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00, 5'h05, 5'h1b};
	localparam logic [7:0][4:0] GREEN_LO = {
		5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07, 5'h0b, 5'h0a};
	localparam logic [7:0][4:0] BLUE_LO = {
		5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f, 5'h11, 5'h10};
	localparam logic [7:0][4:0] RED_HI = {
		5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
	localparam logic [7:0][4:0] GREEN_HI = {
		5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07};
	localparam logic [7:0][4:0] BLUE_HI = {
		5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f};

	// =====================================================================
	// Control positions
	localparam int POS_HSYNC = 24;
	localparam int POS_VSYNC = 25;
	localparam int POS_VALID = 26;
	localparam int POS_SPARE = 23;
	localparam int DROP_BITS = 2;

	// =====================================================================
	// Modes and capture states
	typedef enum logic {
		MAP_LSB_ON_LANE3 = 1'b0,
		MAP_MSB_ON_LANE3 = 1'b1
	} map_mode_t;

	typedef enum logic {
		ST_WAIT = 1'b0,
		ST_CAPTURE = 1'b1
	} capture_state_t;

endpackage : lvds_map_pkg

// ==== src/lane_capture.sv ====
// One lane's seven-slot capture register
`timescale 1ns/1ps
module lane_capture (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Sample request
	input wire logic take,
	input wire logic [2:0] slot,
	input wire logic lane_bit,
	// Captured period
	output logic [lvds_map_pkg::SLOTS-1:0] captured
);

	typedef struct packed {
		logic [lvds_map_pkg::SLOTS-1:0] bits;
	} lane_state_t;

	lane_state_t s_r;
	lane_state_t s_nxt;

	// =====================================================================
	// Slot write: each strobe fills exactly one of the seven bits
	always_comb
	begin
		s_nxt = s_r;
		if (take)
		begin
			s_nxt.bits[slot] = lane_bit;
		end
	end

	// Register the state
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign captured = s_r.bits;

endmodule : lane_capture

// ==== src/lvds_rgb_deser.sv ====
// Seven-to-one display link receiver with RGB bit mapping
`timescale 1ns/1ps
module lvds_rgb_deser #(
	parameter int LANES = 4,
	parameter int OVERSAMPLE = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Link pins
	input wire logic link_clk,
	input wire logic [LANES-1:0] serial_lane,
	// Configuration straps
	input wire logic map_msb_on_lane3,
	input wire logic bpp18,
	// Raw parallel word
	output logic [lvds_map_pkg::WORD_W-1:0] parallel_out_bit,
	output logic word_strobe,
	// Decoded pixel
	output logic [7:0] red,
	output logic [7:0] green,
	output logic [7:0] blue,
	output logic hsync,
	output logic vsync,
	output logic pixel_valid,
	output logic spare_bit
);

	localparam int PH_W = $clog2(OVERSAMPLE);
	localparam int PIN_W = LANES + 3;
	localparam int LANE_BITS = lvds_map_pkg::SLOTS * LANES;
	localparam logic [PH_W-1:0] MID_PHASE = PH_W'(OVERSAMPLE / 2);
	localparam logic [PH_W-1:0] END_PHASE = PH_W'(OVERSAMPLE - 1);
	localparam logic [2:0] LAST = 3'(lvds_map_pkg::LAST_SLOT);

	// Only three or four lanes and a slot of at least two ticks are served
	if (LANES < 3 || LANES > lvds_map_pkg::MAX_LANES)
	begin : g_bad_lanes
		$error("LANES must be 3 or 4");
	end
	if (OVERSAMPLE < 2)
	begin : g_bad_oversample
		$error("OVERSAMPLE must be at least 2");
	end

	typedef struct packed {
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
		logic [PIN_W-1:0] pin_s3;
		logic [PIN_W-1:0] pin_filt;
		lvds_map_pkg::capture_state_t st;
		logic [PH_W-1:0] phase;
		logic [2:0] slot;
		logic load;
		logic [lvds_map_pkg::WORD_W-1:0] word;
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
		logic hsync;
		logic vsync;
		logic pixel_valid;
		logic spare_bit;
		logic word_strobe;
	} deser_state_t;

	deser_state_t s_r;
	deser_state_t s_nxt;
	logic [LANE_BITS-1:0] cap_flat;
	logic take;

	// =====================================================================
	// Per-lane capture registers
	assign take = (s_r.st == lvds_map_pkg::ST_CAPTURE) &&
		(s_r.phase == MID_PHASE);

	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++)
		begin : g_lane
			lane_capture u_lane (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.take(take),
				.slot(s_r.slot),
				.lane_bit(s_r.pin_filt[gl]),
				.captured(cap_flat[gl*lvds_map_pkg::SLOTS +:
					lvds_map_pkg::SLOTS])
			);
		end
	endgenerate

	// =====================================================================
	// Next-state logic
	// Slot timing is derived from the sampled link clock; the link must run
	// at ref_clk / (7 * OVERSAMPLE) for the mid-slot strobe to land right.
	always_comb
	begin
		logic clk_rise;
		logic is_18;
		logic use_msb;
		logic [lvds_map_pkg::WORD_W-1:0] w;
		clk_rise = 1'b0;
		is_18 = 1'b0;
		use_msb = 1'b0;
		w = '0;
		s_nxt = s_r;
		s_nxt.load = 1'b0;
		s_nxt.word_strobe = 1'b0;

		// Three-stage pin sampling; a change counts when stages two and
		// three agree, which rejects a single metastable sample
		s_nxt.pin_s1 = {bpp18, map_msb_on_lane3, link_clk, serial_lane};
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.pin_s3 = s_r.pin_s2;
		for (int i = 0; i < PIN_W; i++)
		begin
			if (s_r.pin_s2[i] == s_r.pin_s3[i])
				s_nxt.pin_filt[i] = s_r.pin_s3[i];
		end
		clk_rise = s_nxt.pin_filt[LANES] && !s_r.pin_filt[LANES];

		// Slot sequencer: a rising link clock opens seven slots
		case (s_r.st)
			lvds_map_pkg::ST_WAIT:
			begin
				if (clk_rise)
				begin
					s_nxt.st = lvds_map_pkg::ST_CAPTURE;
					s_nxt.phase = '0;
					s_nxt.slot = '0;
				end
			end
			lvds_map_pkg::ST_CAPTURE:
			begin
				s_nxt.phase = s_r.phase + 1'b1;
				if (s_r.phase == END_PHASE)
				begin
					s_nxt.phase = '0;
					s_nxt.slot = s_r.slot + 3'h1;
				end
				if (take && s_r.slot == LAST)
				begin
					s_nxt.st = lvds_map_pkg::ST_WAIT;
					s_nxt.load = 1'b1;
				end
			end
			default:
			begin
				s_nxt.st = lvds_map_pkg::ST_WAIT;
			end
		endcase

		// Scatter each lane slot onto its stream position
		for (int k = 0; k < LANE_BITS; k++)
		begin
			w[lvds_map_pkg::SLOT_POS[k]] = cap_flat[k];
		end

		// 18-bit use forces the low-bit arrangement
		is_18 = s_r.pin_filt[LANES+2] || (LANES == 3);
		use_msb = s_r.pin_filt[LANES+1] && !is_18;

		// All outputs change together, once per completed period
		if (s_r.load)
		begin
			s_nxt.word = w;
			s_nxt.word_strobe = 1'b1;
			for (int b = 0; b < 8; b++)
			begin
				if (use_msb)
				begin
					s_nxt.red[b] = w[lvds_map_pkg::RED_HI[b]];
					s_nxt.green[b] = w[lvds_map_pkg::GREEN_HI[b]];
					s_nxt.blue[b] = w[lvds_map_pkg::BLUE_HI[b]];
				end
				else
				begin
					s_nxt.red[b] = w[lvds_map_pkg::RED_LO[b]];
					s_nxt.green[b] = w[lvds_map_pkg::GREEN_LO[b]];
					s_nxt.blue[b] = w[lvds_map_pkg::BLUE_LO[b]];
				end
				if (is_18 && b < lvds_map_pkg::DROP_BITS)
				begin
					s_nxt.red[b] = 1'b0;
					s_nxt.green[b] = 1'b0;
					s_nxt.blue[b] = 1'b0;
				end
			end
			// Control bits sit at the same place in both arrangements
			s_nxt.hsync = w[lvds_map_pkg::POS_HSYNC];
			s_nxt.vsync = w[lvds_map_pkg::POS_VSYNC];
			s_nxt.pixel_valid = w[lvds_map_pkg::POS_VALID];
			s_nxt.spare_bit = w[lvds_map_pkg::POS_SPARE];
		end
	end

	// =====================================================================
	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// =====================================================================
	// Outputs, all straight from flip-flops
	// Three-lane builds leave lane-three positions at zero: 21 live bits
	assign parallel_out_bit = s_r.word;
	assign word_strobe = s_r.word_strobe;
	assign red = s_r.red;
	assign green = s_r.green;
	assign blue = s_r.blue;
	assign hsync = s_r.hsync;
	assign vsync = s_r.vsync;
	assign pixel_valid = s_r.pixel_valid;
	assign spare_bit = s_r.spare_bit;

endmodule : lvds_rgb_deser

// ==== tb/lvds_tx_model.sv ====
// Behavioural seven-to-one transmitter driving the receiver's link pins
`timescale 1ns/1ps
module lvds_tx_model (
	// Clock
	input wire logic ref_clk,
	// Frame request
	input wire logic go,
	input wire logic [27:0] word,
	// Link pins
	output logic link_clk,
	output logic [3:0] serial_lane
);
	// ====
	// Stream position sent in each slot, index lane*7 + slot
	localparam int POS [28] = '{0, 1, 2, 3, 4, 6, 7, 8, 9, 12, 13, 14, 15,
		18, 19, 20, 21, 22, 24, 25, 26, 27, 5, 10, 11, 16, 17, 23};
	logic [27:0] w_r;
	int n = 0;
	initial {link_clk, serial_lane} = '0;
	// A period is 28 cycles, seven slots of four; the clock stands low
	// between frames while idle lanes toggle so no stale bit survives
	always @(negedge ref_clk)
	begin
		if (go && n == 0)
		begin
			w_r = word;
			n = 28;
		end
		if (n != 0)
		begin
			link_clk <= n > 14;
			for (int l = 0; l < 4; l++)
				serial_lane[l] <= w_r[POS[l * 7 + (28 - n) / 4]];
			n--;
		end
		else
		begin
			link_clk <= 1'b0;
			serial_lane <= ~serial_lane;
		end
	end
endmodule : lvds_tx_model

// ==== tb/lvds_rgb_deser_assertions.sv ====
// Concurrent checks on the link receiver's outputs
`timescale 1ns/1ps
module lvds_rgb_deser_assertions #(
	parameter int LANES = 4
) (
	// Clock, reset, pins and straps
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic [LANES-1:0] serial_lane,
	input wire logic map_msb_on_lane3,
	input wire logic bpp18,
	// Outputs
	input wire logic [27:0] parallel_out_bit,
	input wire logic word_strobe,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic pixel_valid,
	input wire logic spare_bit,
	input wire logic [7:0] red,
	input wire logic [7:0] green,
	input wire logic [7:0] blue
);
	// ====
	// Straps settle long before a strobe, so raw strap pins are fine here
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire [27:0] w = parallel_out_bit;
	property p_pulse; word_strobe |=> !word_strobe; endproperty
	a_pulse: assert property (p_pulse)
		else $error("strobe too wide");
	property p_hold;
		!word_strobe |-> $stable(w) && $stable({red, green, blue});
	endproperty
	a_hold: assert property (p_hold)
		else $error("word moved without strobe");
	property p_lat; $rose(link_clk) |-> ##[29:36] word_strobe; endproperty
	a_lat: assert property (p_lat)
		else $error("no word after link clock");
	property p_sync; hsync == w[24] && vsync == w[25]; endproperty
	a_sync: assert property (p_sync)
		else $error("sync position");
	property p_valid; pixel_valid == w[26]; endproperty
	a_valid: assert property (p_valid)
		else $error("valid position");
	property p_spare; spare_bit == w[23]; endproperty
	a_spare: assert property (p_spare)
		else $error("spare position");
	property p_lo;
		word_strobe && !map_msb_on_lane3 && !bpp18 |->
		red == {w[6], w[4:0], w[5], w[27]} &&
		green == {w[14:12], w[9:7], w[11], w[10]} &&
		blue == {w[22:18], w[15], w[17], w[16]};
	endproperty
	a_lo: assert property (p_lo)
		else $error("low-bit colour map");
	property p_hi;
		word_strobe && map_msb_on_lane3 && !bpp18 |->
		red == {w[5], w[27], w[6], w[4:0]} &&
		green == {w[11], w[10], w[14:12], w[9:7]} &&
		blue == {w[17], w[16], w[22:18], w[15]};
	endproperty
	a_hi: assert property (p_hi)
		else $error("high-bit colour map");
	property p_18;
		word_strobe && bpp18 |-> {red[1:0], green[1:0], blue[1:0]} == 6'h0
		&& red[7:2] == {w[6], w[4:0]}
		&& green[7:2] == {w[14:12], w[9:7]}
		&& blue[7:2] == {w[22:18], w[15]};
	endproperty
	a_18: assert property (p_18)
		else $error("reduced colour map");
	c_lo: cover property (word_strobe && !map_msb_on_lane3);
	c_hi: cover property (word_strobe && map_msb_on_lane3 && !bpp18);
	c_18: cover property (word_strobe && bpp18);
endmodule : lvds_rgb_deser_assertions

// ==== tb/lvds_rgb_deser_bit_mapping_tb.sv ====
// Self-checking bench for the link receiver bit mapping
`timescale 1ns/1ps
module lvds_rgb_deser_bit_mapping_tb;
	logic ref_clk = 0, resetn = 0, msb = 0, b18 = 0, go = 0;
	logic link_clk, hs, vs, pv, sp, ws;
	logic [3:0] lane;
	logic [27:0] word = 0, pob;
	logic [7:0] r, g, b;
	logic [55:0] got[$];
	int n_fail = 0, compares = 0, cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	lvds_tx_model tx_u (.ref_clk(ref_clk), .go(go), .word(word),
		.link_clk(link_clk), .serial_lane(lane));
	lvds_rgb_deser dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.link_clk(link_clk), .serial_lane(lane), .map_msb_on_lane3(msb),
		.bpp18(b18), .parallel_out_bit(pob), .word_strobe(ws), .red(r),
		.green(g), .blue(b), .hsync(hs), .vsync(vs), .pixel_valid(pv),
		.spare_bit(sp));
	// ====
	// Collect each strobed pixel; a hang ends the run as a mismatch
	always @(negedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (ws === 1'b1)
			got.push_back({r, g, b, hs, vs, pv, sp, pob});
		if (cyc == 8000)
		begin
			n_fail++;
			test_done();
		end
	end
	function automatic logic [55:0] px(logic [27:0] w, logic hi, logic s18);
		logic [23:0] c;
		c = {w[6], w[4:0], w[5], w[27], w[14:12], w[9:7], w[11], w[10],
			w[22:18], w[15], w[17], w[16]};
		if (hi && !s18)
			c = {w[5], w[27], w[6], w[4:0], w[11], w[10], w[14:12], w[9:7],
				w[17], w[16], w[22:18], w[15]};
		if (s18)
			c = c & 24'hfc_fcfc;
		return {c, w[24], w[25], w[26], w[23], w};
	endfunction : px
	// Lane three is unconnected in reduced use, so its bits are masked
	task automatic chk(logic [27:0] w);
		logic [55:0] e, m, q;
		e = px(w, msb, b18);
		m = b18 ? {28'hfff_fffe, 28'h77c_f3df} : '1;
		q = got.size() ? got.pop_front() : 'x;
		compares++;
		if ((q & m) !== (e & m))
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, q, e);
		end
	endtask : chk
	task automatic send(logic [27:0] w);
		word <= w;
		go <= 1'b1;
		@(negedge ref_clk);
		go <= 1'b0;
		repeat (27) @(negedge ref_clk);
	endtask : send
	task automatic t_walk(logic hi, logic s18);
		msb <= hi;
		b18 <= s18;
		repeat (8) @(negedge ref_clk);
		for (int i = 0; i < 28; i++)
		begin
			send(28'h1 << i);
			repeat (40) @(negedge ref_clk);
			chk(28'h1 << i);
		end
	endtask : t_walk
	task automatic t_b2b;
		msb <= 1'b0;
		b18 <= 1'b0;
		repeat (8) @(negedge ref_clk);
		send(28'h5a5_a5a5);
		send(28'ha5a_5a5a);
		repeat (40) @(negedge ref_clk);
		chk(28'h5a5_a5a5);
		chk(28'ha5a_5a5a);
	endtask : t_b2b
	// Reset mid-run while the link is idle: every output returns to zero
	task automatic t_reset;
		logic [56:0] q;
		msb <= 1'b0;
		b18 <= 1'b0;
		repeat (8) @(negedge ref_clk);
		send(28'h3ff_ffff);
		repeat (40) @(negedge ref_clk);
		chk(28'h3ff_ffff);
		resetn <= 1'b0;
		repeat (2) @(negedge ref_clk);
		q = {ws, r, g, b, hs, vs, pv, sp, pob};
		compares++;
		if (q !== 57'h0)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, q, 57'h0);
		end
		resetn <= 1'b1;
		repeat (8) @(negedge ref_clk);
		send(28'h0c3_5a96);
		repeat (40) @(negedge ref_clk);
		chk(28'h0c3_5a96);
	endtask : t_reset
	task automatic test_done;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (4) @(negedge ref_clk);
		resetn <= 1'b1;
		t_walk(1'b0, 1'b0);
		t_walk(1'b1, 1'b0);
		t_walk(1'b1, 1'b1);
		t_b2b();
		t_reset();
		test_done();
	end
endmodule : lvds_rgb_deser_bit_mapping_tb
bind lvds_rgb_deser lvds_rgb_deser_assertions #(.LANES(LANES)) chk_u (
	.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
	.serial_lane(serial_lane), .map_msb_on_lane3(map_msb_on_lane3),
	.bpp18(bpp18), .parallel_out_bit(parallel_out_bit),
	.word_strobe(word_strobe), .hsync(hsync), .vsync(vsync),
	.pixel_valid(pixel_valid), .spare_bit(spare_bit), .red(red),
	.green(green), .blue(blue));
